// ===== verilog/codec_clock_pkg.sv
`default_nettype none
package codec_clock_pkg;

  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF   = 8'h00;
  localparam logic [ADDR_W-1:0] CLKSEL_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h08;

  // reset values
  localparam logic [DATA_W-1:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CLKSEL_RESET = 32'h0000_0000;

  // field positions, fixed by the struct layouts below
  localparam int CTRL_PLL_POWER_POS    = 0;
  localparam int CTRL_MASTER_POS       = 1;
  localparam int CTRL_MCLK_EN_POS      = 2;
  localparam int CTRL_BCLK_RATIO_POS   = 3;
  localparam int CTRL_ADC_LEFT_POS     = 4;
  localparam int CTRL_ADC_RIGHT_POS    = 5;
  localparam int CLKSEL_OUT_RATIO_POS  = 0;
  localparam int CLKSEL_RATE_POS       = 4;
  localparam int CLKSEL_PLL_REF_POS    = 8;
  localparam int STATUS_MODE_POS       = 0;
  localparam int STATUS_LOCKED_POS     = 2;
  localparam int STATUS_ADC_VALID_POS  = 3;
  localparam int STATUS_DRIVEN_POS     = 4;
  localparam int STATUS_BCLK_ACT_POS   = 5;
  localparam int STATUS_MCLK_ACT_POS   = 6;
  localparam int STATUS_EXT_RATE_POS   = 8;

  // timing
  localparam int CLK_PERIOD_NS      = 100;
  localparam int RESET_PULSE_NS     = 150;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_TIME_US       = 2000;
  localparam int LOCK_CYCLES_DEF    = (LOCK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int ADC_VALID_EDGES    = 1059;
  localparam logic [3:0] BCLK_HALF_CYCLES  = 4'h2;
  localparam logic [3:0] MCLK_INVALID_HALF = 4'h1;
  localparam logic [5:0] FRAME_HALF_32FS   = 6'h10;
  localparam logic [5:0] FRAME_HALF_64FS   = 6'h20;

  typedef enum logic [1:0] {
    MODE_EXT_SLAVE,
    MODE_PLL_SLAVE,
    MODE_UNUSED,
    MODE_PLL_MASTER
  } mode_e;

  typedef struct packed {
    logic [25:0] rsvd;
    logic        adc_right_power;
    logic        adc_left_power;
    logic        bit_clock_ratio;
    logic        mclk_out_en;
    logic        master_select;
    logic        pll_power_bit;
  } ctrl_s;

  typedef struct packed {
    logic [19:0] rsvd_hi;
    logic [3:0]  pll_reference_select;
    logic [3:0]  rate_select;
    logic [1:0]  rsvd_lo;
    logic [1:0]  output_clock_ratio;
  } clksel_s;

  typedef struct packed {
    logic [19:0] rsvd_hi;
    logic [3:0]  ext_rate;
    logic        rsvd_lo;
    logic        mclk_in_active;
    logic        bit_clock_active;
    logic        clocks_driven;
    logic        adc_valid;
    logic        pll_locked;
    logic [1:0]  mode;
  } status_s;

  function automatic mode_e mode_of(input logic pll_on, input logic master);
    if (pll_on && master)
      return MODE_PLL_MASTER;
    else if (pll_on)
      return MODE_PLL_SLAVE;
    else if (master)
      return MODE_UNUSED;
    else
      return MODE_EXT_SLAVE;
  endfunction

endpackage
`default_nettype wire

// ===== verilog/clock_sync.sv
`timescale 1ns/1ps
`default_nettype none
module clock_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  // stage one is read by stage two only
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= '0;
      dout   <= '0;
    end
    else
    begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(
  parameter int CNT_W = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             enable,
  input  wire logic [CNT_W-1:0] half_cycles,
  output logic                  clk_out,
  output logic                  fall_pulse
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_clk_out;
  logic             toggle;

  assign toggle     = enable && (count >= half_cycles - CNT_W'(1));
  // marks the edge at which the output goes low, so callers can align to it
  assign fall_pulse = toggle && clk_out;

  always_comb
  begin
    next_count   = count;
    next_clk_out = clk_out;
    if (!enable)
    begin
      next_count   = '0;
      next_clk_out = 1'b0;
    end
    else if (toggle)
    begin
      next_count   = '0;
      next_clk_out = ~clk_out;
    end
    else
      next_count = count + CNT_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count   <= '0;
      clk_out <= 1'b0;
    end
    else
    begin
      count   <= next_count;
      clk_out <= next_clk_out;
    end
  end

  AST_DIV_LOW_WHEN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    !enable |=> !clk_out)
    else $error("divider output not low while disabled");
endmodule
`default_nettype wire

// ===== verilog/codec_clock_mode_select.sv
// Behaviour
// - pll power and master bits select mode
// - unused mode with enable gives invalid mclk
// - external slave rate from rate field
// - mclk output low unless enabled
// - pll master drives bit and frame clocks
// - master bit one means master, resets zero
// - slave after reset until master written
// - clock pins undriven until master bit set
// - power-down low resets; hold 150 ns
// - adc output valid after 1059 frame rises
// - master clocks held low until pll lock
`timescale 1ns/1ps
`default_nettype none
module codec_clock_mode_select
  import codec_clock_pkg::*;
#(
  parameter int LOCK_CYCLES = codec_clock_pkg::LOCK_CYCLES_DEF
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [codec_clock_pkg::ADDR_W-1:0] paddr,
  input  wire logic [codec_clock_pkg::DATA_W-1:0] pwdata,
  output logic      [codec_clock_pkg::DATA_W-1:0] prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               bit_clock_in,
  output logic                                    bit_clock_out,
  output logic                                    bit_clock_oe_n,
  input  wire logic                               frame_clock_in,
  output logic                                    frame_clock_out,
  output logic                                    frame_clock_oe_n,
  input  wire logic                               master_clock_input,
  output logic                                    master_clock_output,
  output logic                                    adc_serial_valid
);
  import codec_clock_pkg::*;

  localparam int LOCK_W = $clog2(LOCK_CYCLES + 1);
  localparam int ADC_W  = 11;

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == CTRL_OFF) || (a == CLKSEL_OFF) || (a == STATUS_OFF);
  endfunction

  ctrl_s              ctrl;
  ctrl_s              next_ctrl;
  clksel_s            clksel;
  clksel_s            next_clksel;
  status_s            status;
  logic [DATA_W-1:0]  next_prdata;
  mode_e              cur_mode;
  logic               apb_setup;
  logic               apb_write;
  logic               status_read;
  logic               lock_restart;
  logic [LOCK_W-1:0]  lock_count;
  logic [LOCK_W-1:0]  next_lock_count;
  logic               pll_locked;
  logic               next_pll_locked;
  logic               master_run;
  logic               bclk_gen;
  logic               bclk_fall;
  logic               frame_gen;
  logic               next_frame_gen;
  logic [5:0]         frame_bits;
  logic [5:0]         next_frame_bits;
  logic [5:0]         frame_half;
  logic               mclk_enable;
  logic [3:0]         mclk_half;
  logic [2:0]         pin_sync;
  logic [2:0]         pin_prev;
  logic [2:0]         next_pin_prev;
  logic [1:0]         activity;
  logic [1:0]         next_activity;
  logic               frame_level;
  logic               frame_prev;
  logic               next_frame_prev;
  logic               frame_rise;
  logic               adc_on;
  logic               adc_on_prev;
  logic               next_adc_on_prev;
  logic [ADC_W-1:0]   adc_count;
  logic [ADC_W-1:0]   next_adc_count;
  logic               next_adc_valid;

  // ---------------- register bus ----------------
  assign apb_setup   = psel && !penable;
  assign apb_write   = psel && penable && pwrite;
  assign status_read = apb_setup && !pwrite && (paddr == STATUS_OFF);
  assign pready      = psel && penable;
  assign pslverr     = psel && penable && !is_mapped(paddr);

  always_comb
  begin
    next_ctrl   = ctrl;
    next_clksel = clksel;
    if (apb_write)
    begin
      if (paddr == CTRL_OFF)
      begin
        next_ctrl      = ctrl_s'(pwdata);
        next_ctrl.rsvd = '0;
      end
      else if (paddr == CLKSEL_OFF)
      begin
        next_clksel         = clksel_s'(pwdata);
        next_clksel.rsvd_hi = '0;
        next_clksel.rsvd_lo = '0;
      end
    end
  end

  // register reset leaves the part a slave with everything powered off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl   <= ctrl_s'(CTRL_RESET);
      clksel <= clksel_s'(CLKSEL_RESET);
      prdata <= '0;
    end
    else
    begin
      ctrl   <= next_ctrl;
      clksel <= next_clksel;
      prdata <= next_prdata;
    end
  end

  assign cur_mode = mode_of(ctrl.pll_power_bit, ctrl.master_select);

  always_comb
  begin
    status                  = '0;
    status.mode             = cur_mode;
    status.pll_locked       = pll_locked;
    status.adc_valid        = adc_serial_valid;
    status.clocks_driven    = ctrl.master_select;
    status.bit_clock_active = activity[0];
    status.mclk_in_active   = activity[1];
    if (cur_mode == MODE_EXT_SLAVE)
      status.ext_rate = clksel.rate_select;
  end

  // read data is captured in the setup cycle so it comes from a flop
  always_comb
  begin
    next_prdata = prdata;
    if (apb_setup && !pwrite)
    begin
      if (paddr == CTRL_OFF)
        next_prdata = DATA_W'(ctrl);
      else if (paddr == CLKSEL_OFF)
        next_prdata = DATA_W'(clksel);
      else if (paddr == STATUS_OFF)
        next_prdata = DATA_W'(status);
      else
        next_prdata = '0;
    end
  end

  // ---------------- pll lock model ----------------
  // a change of reference or rate while running restarts the lock wait
  assign lock_restart = (next_clksel.rate_select != clksel.rate_select) ||
                        (next_clksel.pll_reference_select != clksel.pll_reference_select);

  always_comb
  begin
    next_lock_count = lock_count;
    next_pll_locked = pll_locked;
    if (!ctrl.pll_power_bit || lock_restart)
    begin
      next_lock_count = '0;
      next_pll_locked = 1'b0;
    end
    else if (!pll_locked)
    begin
      if (lock_count == LOCK_W'(LOCK_CYCLES - 1))
        next_pll_locked = 1'b1;
      else
        next_lock_count = lock_count + LOCK_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_count <= '0;
      pll_locked <= 1'b0;
    end
    else
    begin
      lock_count <= next_lock_count;
      pll_locked <= next_pll_locked;
    end
  end

  // ---------------- master clock generation ----------------
  assign master_run = ctrl.master_select && ctrl.pll_power_bit && pll_locked;

  clock_divider #(
    .CNT_W (4)
  ) u_bclk_div (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (master_run),
    .half_cycles (BCLK_HALF_CYCLES),
    .clk_out     (bclk_gen),
    .fall_pulse  (bclk_fall)
  );

  assign frame_half = ctrl.bit_clock_ratio ? FRAME_HALF_64FS : FRAME_HALF_32FS;

  // frame edges follow bit-clock falls, keeping them off bit-clock rises
  always_comb
  begin
    next_frame_gen  = frame_gen;
    next_frame_bits = frame_bits;
    if (!master_run)
    begin
      next_frame_gen  = 1'b0;
      next_frame_bits = '0;
    end
    else if (bclk_fall)
    begin
      // greater-or-equal so a switch to the shorter frame cannot run the count past its end
      if (frame_bits >= frame_half - 6'h01)
      begin
        next_frame_gen  = ~frame_gen;
        next_frame_bits = '0;
      end
      else
        next_frame_bits = frame_bits + 6'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_gen  <= 1'b0;
      frame_bits <= '0;
    end
    else
    begin
      frame_gen  <= next_frame_gen;
      frame_bits <= next_frame_bits;
    end
  end

  // pins float until master is chosen; before lock they are driven low
  assign bit_clock_oe_n   = !ctrl.master_select;
  assign frame_clock_oe_n = !ctrl.master_select;
  assign bit_clock_out    = bclk_gen;
  assign frame_clock_out  = frame_gen;

  // without lock, or in the unused mode, the divider runs at its fastest: an invalid clock
  assign mclk_enable = ctrl.mclk_out_en && (ctrl.pll_power_bit || ctrl.master_select);
  assign mclk_half   = (ctrl.pll_power_bit && pll_locked) ?
                       4'(4'h1 << clksel.output_clock_ratio) : MCLK_INVALID_HALF;

  clock_divider #(
    .CNT_W (4)
  ) u_mclk_div (
    .pclk        (pclk),
    .presetn     (presetn),
    .enable      (mclk_enable),
    .half_cycles (mclk_half),
    .clk_out     (master_clock_output),
    .fall_pulse  ()
  );

  // ---------------- input pins and adc start-up ----------------
  clock_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({master_clock_input, frame_clock_in, bit_clock_in}),
    .dout    (pin_sync)
  );

  assign frame_level = master_run ? frame_gen : pin_sync[1];
  assign frame_rise  = frame_level && !frame_prev;
  assign adc_on      = ctrl.adc_left_power || ctrl.adc_right_power;

  always_comb
  begin
    next_pin_prev    = pin_sync;
    next_frame_prev  = frame_level;
    next_adc_on_prev = adc_on;
    // read clears the activity flags, but an edge in that cycle wins
    next_activity    = status_read ? 2'b00 : activity;
    if (pin_sync[0] != pin_prev[0])
      next_activity[0] = 1'b1;
    if (pin_sync[2] != pin_prev[2])
      next_activity[1] = 1'b1;
    next_adc_count = adc_count;
    next_adc_valid = adc_serial_valid;
    // only the first channel power-up starts the wait; a second one joins a running count
    if (!adc_on || !adc_on_prev)
    begin
      next_adc_count = '0;
      next_adc_valid = 1'b0;
    end
    else if (frame_rise && !adc_serial_valid)
    begin
      if (adc_count == ADC_W'(ADC_VALID_EDGES - 1))
        next_adc_valid = 1'b1;
      else
        next_adc_count = adc_count + ADC_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_prev         <= '0;
      frame_prev       <= 1'b0;
      adc_on_prev      <= 1'b0;
      activity         <= '0;
      adc_count        <= '0;
      adc_serial_valid <= 1'b0;
    end
    else
    begin
      pin_prev         <= next_pin_prev;
      frame_prev       <= next_frame_prev;
      adc_on_prev      <= next_adc_on_prev;
      activity         <= next_activity;
      adc_count        <= next_adc_count;
      adc_serial_valid <= next_adc_valid;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_pll_started;
    $rose(ctrl.pll_power_bit) && ctrl.master_select;
  endsequence

  sequence s_unused_enabled;
    (cur_mode == MODE_UNUSED && ctrl.mclk_out_en)[*3];
  endsequence

  AST_MODE_DECODE: assert property (
    (ctrl.pll_power_bit && !ctrl.master_select) |-> status.mode == 2'(MODE_PLL_SLAVE))
    else $error("pll slave mode decoded wrongly");
  AST_UNUSED_INVALID_MCLK: assert property (
    s_unused_enabled |-> ##[0:2] $changed(master_clock_output))
    else $error("no clock on mclk output in unused mode");
  AST_EXT_RATE: assert property (
    status.ext_rate == ((cur_mode == MODE_EXT_SLAVE) ? clksel.rate_select : 4'h0))
    else $error("external rate field wrong");
  AST_MCLK_LOW: assert property (
    (!ctrl.mclk_out_en && $past(!ctrl.mclk_out_en)) |-> !master_clock_output)
    else $error("mclk output not low while disabled");
  AST_FRAME_ON_BCLK_FALL: assert property (
    (master_run && $changed(frame_gen)) |-> $fell(bclk_gen))
    else $error("frame clock edge not on bit clock fall");
  AST_SLAVE_AFTER_RESET: assert property (
    $past(!presetn) |-> (!ctrl.master_select && bit_clock_oe_n))
    else $error("not slave after reset");
  AST_FLOAT_UNTIL_MASTER: assert property (
    !ctrl.master_select |-> (bit_clock_oe_n && frame_clock_oe_n && !bit_clock_out && !frame_clock_out))
    else $error("clock pins driven before master selected");
  AST_LOW_BEFORE_LOCK: assert property (
    s_pll_started |=> (!bit_clock_out && !frame_clock_out) throughout (!pll_locked)[*8])
    else $error("master clocks toggled before lock");
  AST_LOCK_TIME: assert property (
    $rose(pll_locked) |-> $past(lock_count) == LOCK_W'(LOCK_CYCLES - 1))
    else $error("lock reached at wrong count");
  AST_ADC_VALID_COUNT: assert property (
    $rose(adc_serial_valid) |-> ($past(adc_count) == ADC_W'(ADC_VALID_EDGES - 1) && $past(frame_rise)))
    else $error("adc valid at wrong frame count");
  AST_SLVERR_UNMAPPED: assert property (
    (psel && penable) |-> (pslverr == !is_mapped(paddr)))
    else $error("slave error on wrong address");
endmodule
`default_nettype wire

// ===== verif/audio_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module audio_host_model (
  input  wire logic run,
  input  wire logic wide,
  input  wire logic mclk_run,
  output logic      bclk,
  output logic      fclk,
  output logic      mclk
);
  int falls;

  // frame flips only on a bit clock fall, so no bit rise meets a frame edge
  always
  begin
    if (!run)
    begin
      bclk = 1'b0;
      fclk = 1'b0;
      falls = 0;
      @(posedge run);
      #137;
    end
    else
    begin
      #400;
      bclk = ~bclk;
      if (!bclk)
      begin
        falls++;
        if (falls == (wide ? 32 : 16))
        begin
          falls = 0;
          fclk = ~fclk;
        end
      end
    end
  end

  // grounded unless asked to run, as needed when frame or bit clock is the reference
  always
  begin
    mclk = 1'b0;
    wait (mclk_run);
    while (mclk_run)
      #41 mclk = ~mclk;
  end
endmodule
`default_nettype wire

// ===== verif/codec_clock_mode_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module codec_clock_mode_select_bench;
  import codec_clock_pkg::*;
  localparam int LOCK  = 20;
  localparam int LIMIT = 30000;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic        bo, boe_n, fo, foe_n, mco, adc_v, host_run, host_wide, mclk_run;
  logic        hb, hf, hm, bit_pin, frame_pin, errv;
  int          miscompares, samples_checked, cycles, n;
  mode_e       exp_mode [4] = '{MODE_EXT_SLAVE, MODE_PLL_SLAVE, MODE_UNUSED, MODE_PLL_MASTER};

  // released pins fall to the external pull-down
  assign bit_pin   = !boe_n ? bo : (host_run ? hb : 1'b0);
  assign frame_pin = !foe_n ? fo : (host_run ? hf : 1'b0);

  codec_clock_mode_select #(.LOCK_CYCLES(LOCK)) i_codec_clock_mode_select (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bit_clock_in(bit_pin), .bit_clock_out(bo), .bit_clock_oe_n(boe_n),
    .frame_clock_in(frame_pin), .frame_clock_out(fo), .frame_clock_oe_n(foe_n),
    .master_clock_input(hm), .master_clock_output(mco), .adc_serial_valid(adc_v));

  audio_host_model i_audio_host_model (
    .run(host_run), .wide(host_wide), .mclk_run(mclk_run), .bclk(hb), .fclk(hf), .mclk(hm));

  always #50 pclk = ~pclk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdv  = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rdv, exp);
    check(errv, 32'h0);
  endtask

  function automatic logic [31:0] ctrl(input logic p, m, e, r, a);
    ctrl_s c;
    c = '0;
    c.pll_power_bit   = p;
    c.master_select   = m;
    c.mclk_out_en     = e;
    c.bit_clock_ratio = r;
    c.adc_left_power  = a;
    return c;
  endfunction

  function automatic logic pick(input int s);
    case (s)
      0:       return bo;
      1:       return fo;
      2:       return mco;
      4:       return frame_pin;
      default: return 1'b1;
    endcase
  endfunction

  // counts rises of a (or cycles when a is 3) over one period of b
  task automatic edges(input int a, input int b, output int cnt);
    logic pa, pb, go;
    cnt = 0;
    pb = pick(b);
    do
    begin
      @(posedge pclk);
      go = pick(b) && !pb;
      pb = pick(b);
    end while (!go);
    pa = pick(a);
    do
    begin
      @(posedge pclk);
      if (a == 3 || (pick(a) && !pa))
        cnt++;
      pa = pick(a);
      go = pick(b) && !pb;
      pb = pick(b);
    end while (!go);
  endtask

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {host_run, host_wide, mclk_run} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CTRL_OFF, CTRL_RESET);
    rdc(CLKSEL_OFF, CLKSEL_RESET);
    rdc(STATUS_OFF, 32'h0);
    check({boe_n, foe_n}, 32'h3);
    xfer(1'b0, 8'h0c, 32'h0);
    check(errv, 32'h1);
    check(rdv, 32'h0);
    xfer(1'b1, STATUS_OFF, 32'hffff_ffff);
    rdc(STATUS_OFF, 32'h0);
    xfer(1'b1, CLKSEL_OFF, 32'h50);
    xfer(1'b1, CTRL_OFF, ctrl(0, 0, 1, 0, 0));
    rdc(STATUS_OFF, 32'h500);
    host_run <= 1'b1;
    mclk_run <= 1'b1;
    edges(3, 4, n);
    check(mco, 32'h0);
    rdc(STATUS_OFF, 32'h560);
    host_run <= 1'b0;
    mclk_run <= 1'b0;
    // lets the pin synchronisers drain before the activity flags are read
    repeat (8) @(posedge pclk);
    xfer(1'b0, STATUS_OFF, 32'h0);
    rdc(STATUS_OFF, 32'h500);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, CTRL_OFF, ctrl(i[0], i[1], 0, 0, 0));
      xfer(1'b0, STATUS_OFF, 32'h0);
      check(rdv & 32'h3, 32'(exp_mode[i]));
      check({boe_n, foe_n}, i[1] ? 32'h0 : 32'h3);
    end
    check({bo, fo}, 32'h0);
    do
      xfer(1'b0, STATUS_OFF, 32'h0);
    while (rdv[STATUS_LOCKED_POS] !== 1'b1);
    edges(3, 0, n);
    check(n, 2 * BCLK_HALF_CYCLES);
    edges(0, 1, n);
    edges(0, 1, n);
    check(n, 2 * FRAME_HALF_32FS);
    xfer(1'b1, CTRL_OFF, ctrl(1, 1, 0, 1, 0));
    edges(0, 1, n);
    edges(0, 1, n);
    check(n, 2 * FRAME_HALF_64FS);
    xfer(1'b1, CTRL_OFF, ctrl(1, 1, 1, 1, 0));
    for (int r = 0; r < 4; r++)
    begin
      xfer(1'b1, CLKSEL_OFF, 32'h50 | r);
      edges(3, 2, n);
      edges(3, 2, n);
      check(n, 2 << r);
    end
    xfer(1'b1, CTRL_OFF, ctrl(1, 1, 0, 1, 0));
    n = 0;
    // the divider still sees the old enable at the write edge, so one more toggle may show
    @(posedge pclk);
    repeat (16)
    begin
      @(posedge pclk);
      n += mco;
    end
    check(n, 0);
    xfer(1'b1, CTRL_OFF, ctrl(0, 1, 1, 0, 0));
    edges(3, 2, n);
    edges(3, 2, n);
    check(n, 2 * MCLK_INVALID_HALF);
    check(boe_n, 32'h0);
    xfer(1'b1, CLKSEL_OFF, 32'h0);
    xfer(1'b1, CTRL_OFF, ctrl(1, 0, 0, 0, 1));
    host_run <= 1'b1;
    // the full count would overrun the run length: only early validity is ruled out
    repeat (3) edges(3, 4, n);
    check({boe_n, foe_n}, 32'h3);
    check(adc_v, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn  <= 1'b1;
    host_run <= 1'b0;
    check({boe_n, foe_n, adc_v}, 32'h6);
    rdc(CTRL_OFF, CTRL_RESET);
    tally_and_finish();
  end
endmodule
`default_nettype wire
